// ===== bench/tb.sv
// Self-checking testbench for the I/O port watchdog timer
`timescale 1ns/1ns
module tb;
  import iowdt_pkg::*;
  // ---------------------------------------------------------------
  // Signals and design
  // ---------------------------------------------------------------
  localparam int     TC = 10;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic [15:0]       addr = 16'h0000;
  logic [7:0]        wdata = 8'h00;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              sel = 1'b0;
  logic [7:0]        rdata;
  logic              cpu_rst;
  logic              cpu_irq;
  int                mismatches = 0;
  int                checks = 0;
  int                first;
  int                n_rst;
  int                n_irq;

  iowdt_top #(.TICK_CYCLES_P(TC)) u_iowdt_top (
    .I_REF_CLK  (clk),
    .I_SYS_RST  (rst),
    .I_IO_ADDR  (addr),
    .I_IO_WDATA (wdata),
    .I_IO_WR    (wr),
    .I_IO_RD    (rd),
    .I_ACT_SEL  (sel),
    .O_IO_RDATA (rdata),
    .O_CPU_RST  (cpu_rst),
    .O_CPU_IRQ  (cpu_irq)
  );

  always #10 clk = ~clk;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // One port access; returns just after the taking edge
  task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask

  // Watch the expiry outputs for a number of cycles
  task automatic watch(input int lim, input int f, input int r, input int q, input string t);
    first = 0;
    n_rst = 0;
    n_irq = 0;
    for (int i = 1; i <= lim; i++) begin
      @(posedge clk);
      #1;
      if ((cpu_rst === 1'b1 || cpu_irq === 1'b1) && first == 0) first = i;
      if (cpu_rst === 1'b1) n_rst++;
      if (cpu_irq === 1'b1) n_irq++;
    end
    check({t, " expiry cycle"}, first, f);
    check({t, " reset pulses"}, n_rst, r);
    check({t, " irq pulses"}, n_irq, q);
    $display("test %s done", t);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    #100000;
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("rdata after reset", rdata, 8'h00);
    watch(50, 0, 0, 0, "idle");
    io(1'b1, 16'h0442, 8'h01);
    watch(30, 0, 0, 0, "other address");
    io(1'b1, WDT_PORT_ADDR, 8'h02);
    watch(60, 2 * TC, 1, 0, "reset action");
    @(posedge clk) sel <= 1'b1;
    io(1'b1, WDT_PORT_ADDR, WDT_INTV_MAX);
    watch(640, 63 * TC, 0, 1, "top value");
    io(1'b1, WDT_PORT_ADDR, 8'h03);
    watch(15, 0, 0, 0, "before refresh");
    io(1'b1, WDT_PORT_ADDR, 8'h01);
    watch(30, TC, 0, 1, "refresh");
    io(1'b1, WDT_PORT_ADDR, 8'h01);
    io(1'b0, 16'h0442, 8'h00);
    check("rdata other read", rdata, 8'h00);
    watch(30, TC - 2, 0, 1, "other read");
    io(1'b1, WDT_PORT_ADDR, 8'h02);
    watch(5, 0, 0, 0, "armed");
    io(1'b0, WDT_PORT_ADDR, 8'h00);
    check("read data", rdata, 8'h02);
    watch(60, 0, 0, 0, "disable");
    io(1'b1, WDT_PORT_ADDR, 8'h02);
    @(posedge clk) rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    #1;
    check("rdata mid-run reset", rdata, 8'h00);
    watch(60, 0, 0, 0, "mid-run reset");
    io(1'b1, WDT_PORT_ADDR, 8'h01);
    watch(30, TC, 0, 1, "rearm after reset");
    tally_and_finish();
  end
endmodule

// ===== rtl/iowdt_pkg.sv
// Package with constants and types for the I/O port watchdog
package iowdt_pkg;

  // ---------------------------------------------------------------
  // Port decode and data
  // ---------------------------------------------------------------
  localparam int          ADDR_W          = 16;
  localparam logic [15:0] WDT_PORT_ADDR   = 16'h0443;
  localparam int          DATA_W          = 8;
  localparam logic [7:0]  WDT_INTV_MIN    = 8'h01;
  localparam logic [7:0]  WDT_INTV_MAX    = 8'h3F;
  localparam logic [5:0]  WDT_INTV_RST    = 6'h00;
  localparam logic [7:0]  RDATA_RST       = 8'h00;

  // ---------------------------------------------------------------
  // Time base
  // ---------------------------------------------------------------
  localparam int          CLK_HZ          = 50000000;
  localparam int          TICK_SEC        = 1;
  localparam int          TICK_CYCLES     = CLK_HZ * TICK_SEC;
  localparam int          TICK_W          = 26;
  localparam logic [25:0] TICK_CNT_RST    = 26'h0000000;
  localparam logic [5:0]  SEC_CNT_RST     = 6'h00;
  localparam logic [31:0] SINCE_WR_RST    = 32'h00000000;

  // Action on expiry
  localparam logic        ACT_RESET       = 1'b0;
  localparam logic        ACT_IRQ         = 1'b1;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    IOWDT_IDLE    = 2'b00,
    IOWDT_RUN     = 2'b01,
    IOWDT_EXPIRED = 2'b11
  } iowdt_state_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } iowdt_io_t;

endpackage

// ===== rtl/iowdt_top.sv
// I/O port watchdog timer with a one-second time base
`timescale 1ns/1ns
module iowdt_top
  import iowdt_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  input  wire logic              I_REF_CLK,
  input  wire logic              I_SYS_RST,
  input  wire logic [ADDR_W-1:0] I_IO_ADDR,
  input  wire logic [DATA_W-1:0] I_IO_WDATA,
  input  wire logic              I_IO_WR,
  input  wire logic              I_IO_RD,
  input  wire logic              I_ACT_SEL,
  output logic      [DATA_W-1:0] O_IO_RDATA,
  output logic                   O_CPU_RST,
  output logic                   O_CPU_IRQ
);

  // ---------------------------------------------------------------
  // Port decode
  // ---------------------------------------------------------------
  iowdt_io_t io;
  logic      hit_wr;
  logic      hit_rd;

  assign io.addr  = I_IO_ADDR;
  assign io.wdata = I_IO_WDATA;
  assign io.wr    = I_IO_WR;
  assign io.rd    = I_IO_RD;

  function automatic logic port_hit(input logic [15:0] a);
    port_hit = (a == WDT_PORT_ADDR);
  endfunction

  // Read takes precedence over a same-cycle write
  assign hit_rd = io.rd & port_hit(io.addr);
  assign hit_wr = io.wr & port_hit(io.addr) & ~hit_rd;

  // ---------------------------------------------------------------
  // State, counters and outputs
  // ---------------------------------------------------------------
  iowdt_state_t      state_r,   state_nxt;
  logic [TICK_W-1:0] tick_r,    tick_nxt;
  logic [5:0]        sec_r,     sec_nxt;
  logic [5:0]        intv_r,    intv_nxt;
  logic [7:0]        rdata_r,   rdata_nxt;
  logic              rst_r,     rst_nxt;
  logic              irq_r,     irq_nxt;
  logic              tick_en;

  assign tick_en = (tick_r == TICK_W'(TICK_CYCLES_P - 1));

  always_comb begin
    state_nxt = state_r;
    tick_nxt  = tick_r;
    sec_nxt   = sec_r;
    intv_nxt  = intv_r;
    rdata_nxt = rdata_r;
    rst_nxt   = 1'b0;
    irq_nxt   = 1'b0;
    if (hit_rd) begin
      state_nxt = IOWDT_IDLE;
      rdata_nxt = {2'b00, intv_r};
    end else if (hit_wr) begin
      intv_nxt  = io.wdata[5:0];
      sec_nxt   = io.wdata[5:0];
      tick_nxt  = TICK_CNT_RST;
      state_nxt = IOWDT_RUN;
    end else begin
      case (state_r)
        IOWDT_IDLE: begin
          tick_nxt = TICK_CNT_RST;
        end
        IOWDT_RUN: begin
          if (tick_en) begin
            tick_nxt = TICK_CNT_RST;
            if (sec_r <= 6'h01) begin
              state_nxt = IOWDT_EXPIRED;
              sec_nxt   = SEC_CNT_RST;
              rst_nxt   = (I_ACT_SEL == ACT_RESET);
              irq_nxt   = (I_ACT_SEL == ACT_IRQ);
            end else begin
              sec_nxt = sec_r - 6'h01;
            end
          end else begin
            tick_nxt = tick_r + TICK_W'(1);
          end
        end
        IOWDT_EXPIRED: begin
          tick_nxt = TICK_CNT_RST;
        end
        default: begin
          state_nxt = IOWDT_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_r <= IOWDT_IDLE;
      tick_r  <= TICK_CNT_RST;
      sec_r   <= SEC_CNT_RST;
      intv_r  <= WDT_INTV_RST;
      rdata_r <= RDATA_RST;
      rst_r   <= 1'b0;
      irq_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tick_r  <= tick_nxt;
      sec_r   <= sec_nxt;
      intv_r  <= intv_nxt;
      rdata_r <= rdata_nxt;
      rst_r   <= rst_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign O_IO_RDATA = rdata_r;
  assign O_CPU_RST  = rst_r;
  assign O_CPU_IRQ  = irq_r;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence s_port_read;
    hit_rd;
  endsequence

  sequence s_quiet2;
    !O_CPU_RST && !O_CPU_IRQ ##1 !O_CPU_RST && !O_CPU_IRQ;
  endsequence

  sequence s_last_tick;
    state_r == IOWDT_RUN && tick_en && sec_r <= 6'h01 && !hit_wr && !hit_rd;
  endsequence

  // Cycles spent counting since the last arming write
  logic [31:0] since_wr_r,  since_wr_nxt;

  always_comb begin
    since_wr_nxt = since_wr_r;
    if (hit_wr) begin
      since_wr_nxt = SINCE_WR_RST;
    end else if (state_r == IOWDT_RUN) begin
      since_wr_nxt = since_wr_r + 32'h00000001;
    end
  end

  always_ff @(posedge I_REF_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      since_wr_r <= SINCE_WR_RST;
    end else begin
      since_wr_r <= since_wr_nxt;
    end
  end

  chk_idle_no_fire: assert property (state_r == IOWDT_IDLE |=> !O_CPU_RST && !O_CPU_IRQ)
    else $error("Timeout fired while disabled");

  chk_read_disables: assert property (s_port_read |=> state_r == IOWDT_IDLE ##0 s_quiet2)
    else $error("Read did not disable watchdog");

  chk_write_arms: assert property (
    hit_wr |=> state_r == IOWDT_RUN && sec_r == $past(io.wdata[5:0]))
    else $error("Write did not arm watchdog");

  chk_write_reload: assert property (
    hit_wr |=> tick_r == TICK_CNT_RST && intv_r == $past(io.wdata[5:0]))
    else $error("Rewrite did not restart countdown");

  chk_sec_step: assert property (
    state_r == IOWDT_RUN && tick_en && !hit_wr && !hit_rd && sec_r > 6'h01
    |=> sec_r == $past(sec_r) - 6'h01)
    else $error("Seconds counter did not step by one");

  chk_expire_act: assert property ($rose(state_r == IOWDT_EXPIRED) |-> O_CPU_RST ^ O_CPU_IRQ)
    else $error("Expiry gave no action");

  chk_act_select: assert property (O_CPU_IRQ |-> $past(I_ACT_SEL) == ACT_IRQ)
    else $error("Wrong expiry action");

  chk_one_pulse: assert property (O_CPU_RST |=> !O_CPU_RST)
    else $error("Reset pulse longer than one cycle");

  chk_irq_pulse: assert property (O_CPU_IRQ |=> !O_CPU_IRQ)
    else $error("Interrupt pulse longer than one cycle");

  chk_act_reset: assert property (O_CPU_RST |-> $past(I_ACT_SEL) == ACT_RESET)
    else $error("Reset pulse with interrupt selected");

  chk_expired_quiet: assert property (
    state_r == IOWDT_EXPIRED |=> !O_CPU_RST && !O_CPU_IRQ)
    else $error("Expiry action repeated");

  chk_expire_step: assert property (
    s_last_tick |=> state_r == IOWDT_EXPIRED && (O_CPU_RST || O_CPU_IRQ))
    else $error("Last second did not expire");

  chk_expire_time: assert property (
    $rose(state_r == IOWDT_EXPIRED) && intv_r != 6'h00
    |-> since_wr_r == 32'(intv_r) * 32'(TICK_CYCLES_P))
    else $error("Expiry not at interval times one second");

  chk_tick_bound: assert property (tick_r <= TICK_W'(TICK_CYCLES_P - 1))
    else $error("Tick counter past one second");

  chk_idle_holds: assert property (
    state_r == IOWDT_IDLE && !hit_wr |=> state_r == IOWDT_IDLE)
    else $error("Watchdog armed without a write");

  chk_rdata_value: assert property (
    hit_rd |=> O_IO_RDATA == {2'h0, $past(intv_r)})
    else $error("Read data is not the interval");

  chk_rdata_hold: assert property (!hit_rd |=> $stable(O_IO_RDATA))
    else $error("Read data changed without a read");

  chk_other_port: assert property (
    (io.wr || io.rd) && !port_hit(io.addr) |=> $stable(intv_r) && $stable(O_IO_RDATA))
    else $error("Other port access changed the watchdog");

endmodule
